// >>> hw/dhc_cursor.sv
// Purpose: Dual hardware cursor placement, pattern fetch and pixel overlay
// Assumes: Pattern bits for a fetch request arrive in the same cycle as the request
// Notes:   Position to overlay output latency is two clocks

module dhc_cursor
    import dhc_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   ce,
    // Cursor configuration
    input  wire dhc_cur_cfg_t [1:0]     cfg,
    input  wire logic [7:0]             pixel_pipeline_config_zero,
    input  wire logic [2:0]             pal_sub_index,
    // Display timing
    input  wire logic [11:0]            h_pos,
    input  wire logic [11:0]            v_pos,
    input  wire logic [11:0]            border_left,
    input  wire logic [11:0]            border_top,
    input  wire logic                   border_en,
    input  wire logic                   panel_active,
    input  wire logic [1:0]             main_hshift,
    input  wire logic [1:0]             main_vshift,
    input  wire logic                   frame_tick,
    // Frame buffer
    input  wire logic [23:0]            fb_start,
    output logic [1:0]                  fetch_req,
    output logic [1:0][23:0]            fetch_addr,
    output logic [1:0][6:0]             fetch_col,
    input  wire logic [1:0][1:0]        pat_bits,
    // Pixel pipeline
    output logic                        ovl_valid,
    output logic                        ovl_invert,
    output logic [2:0]                  ovl_index,
    output logic                        pal_alt_access,
    output logic [2:0]                  pal_alt_index
);

    dhc_state_t r;
    dhc_state_t next_r;
    dhc_fetch_t [1:0] cand;

    // ==========================================================
    // Per-cursor placement and address
    for (genvar i = 0; i < 2; i++) begin : g_cur
        dhc_mode_t   m;
        logic [7:0]  w;
        logic [7:0]  h;
        logic [1:0]  hs;
        logic [1:0]  vs;
        logic [11:0] ox;
        logic [11:0] oy;
        logic [13:0] rx;
        logic [13:0] ry;
        logic [13:0] ext_w;
        logic [13:0] ext_h;
        logic [7:0]  line;
        logic [3:0]  sel;
        logic [3:0]  lsh;
        logic [23:0] off;
        logic [23:0] lofs;
        logic        shown;

        assign m = dhc_mode_t'(cfg[i].ctrl[CTL_MODE_LSB +: CTL_MODE_W]);
        // Width follows the mode only, so extension cannot widen it
        assign w = (m == DHC_M32_AX) ? W32 :
                   (m == DHC_M128_2C || m == DHC_M128_1T) ? W128 : W64;
        assign h = cfg[i].ctrl[CTL_VEXT] ? cfg[i].height : w;
        // The cursor's own bits and panel_active gate stretching; amounts are the main image's
        assign hs = (cfg[i].ctrl[CTL_HSTR] && panel_active) ? main_hshift : 2'h0;
        assign vs = (cfg[i].ctrl[CTL_VSTR] && panel_active) ? main_vshift : 2'h0;
        assign ox = cfg[i].ctrl[CTL_ORG] ? 12'h000 : border_left;
        assign oy = cfg[i].ctrl[CTL_ORG] ? 12'h000 : border_top;
        // Two spare bits make an underflow land far above any extent
        assign rx = {2'b00, h_pos} - {2'b00, ox} - {2'b00, cfg[i].x};
        assign ry = {2'b00, v_pos} - {2'b00, oy} - {2'b00, cfg[i].y};
        assign ext_w = 14'({6'h00, w} << hs);
        assign ext_h = 14'({6'h00, h} << vs);
        assign line = 8'(ry >> vs);
        assign sel = (m == DHC_M32_AX) ? cfg[i].base_low[7:4] :
                     (w == W128) ? {cfg[i].base_low[7], 3'b000} :
                     {cfg[i].base_low[7:6], 2'b00};
        assign lsh = (m == DHC_M32_AX) ? LSH_NARROW : LSH_WIDE;
        // 4KB region from base bits, pattern chosen inside it
        assign off = {cfg[i].base_high, cfg[i].base_low[3:0], sel, PAT_LOW};
        assign lofs = 24'({16'h0000, line} << lsh);
        assign shown = !cfg[i].ctrl[CTL_BLINK] || r.blink_on;

        always_comb begin
            cand[i].hit  = (m != DHC_OFF) && (m != DHC_OFF7) && shown
                           && (rx < ext_w) && (ry < ext_h);
            cand[i].mode = m;
            cand[i].col  = 7'(rx >> hs);
            cand[i].addr = fb_start + off + lofs;
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        logic       draw;
        logic       inv;
        logic [1:0] color;
        logic [1:0] p;
        int         k;
        draw  = 1'b0;
        inv   = 1'b0;
        color = 2'h0;
        p     = 2'h0;
        k     = 0;
        next_r = r;
        next_r.f = cand;
        // First cursor has priority where both overlap
        if (r.f[0].hit) begin
            k = 0;
        end else begin
            k = 1;
        end
        p = pat_bits[k];
        if (r.f[k].hit) begin
            case (r.f[k].mode)
                DHC_M32_AX, DHC_M64_AX: begin
                    draw  = !p[0];
                    inv   = p[0] && p[1];
                    color = {1'b0, p[1]};
                end
                DHC_M64_4C: begin
                    draw  = 1'b1;
                    color = {p[1], p[0]};
                end
                DHC_M64_3T: begin
                    draw  = ({p[1], p[0]} != TRANS_3T);
                    color = {p[1], p[0]};
                end
                DHC_M128_2C: begin
                    draw  = 1'b1;
                    color = {1'b0, p[0]};
                end
                DHC_M128_1T: begin
                    draw  = p[0];
                    color = 2'h0;
                end
                default: begin
                    draw = 1'b0;
                end
            endcase
        end
        // Border colors occupy the first cursor's upper two entries
        if (k == 0 && border_en) begin
            color[1] = 1'b0;
        end
        next_r.ovl_valid  = draw || inv;
        next_r.ovl_invert = inv && !draw;
        next_r.ovl_index  = draw ? ((k == 0 ? PAL_C1 : PAL_C2) | {1'b0, color}) : 3'h0;
        next_r.alt_access = pixel_pipeline_config_zero[ALT_SEL_BIT];
        next_r.alt_index  = pal_sub_index;
        if (frame_tick) begin
            next_r.blink_cnt = r.blink_cnt + 4'h1;
            if (r.blink_cnt == BLINK_LAST) begin
                next_r.blink_on = !r.blink_on;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r          <= '0;
            r.blink_on <= 1'b1;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // ==========================================================
    // Outputs; the frame buffer port is read-only
    always_comb begin
        for (int j = 0; j < 2; j++) begin
            fetch_req[j]  = r.f[j].hit;
            fetch_addr[j] = r.f[j].addr;
            fetch_col[j]  = r.f[j].col;
        end
    end
    assign ovl_valid      = r.ovl_valid;
    assign ovl_invert     = r.ovl_invert;
    assign ovl_index      = r.ovl_index;
    assign pal_alt_access = r.alt_access;
    assign pal_alt_index  = r.alt_index;

    // ==========================================================
    // Checks
    a_mode_off_idle: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg[0].ctrl[2:0] == DHC_OFF |=> !fetch_req[0])
        else $error("disabled cursor requested a fetch");

    a_blink_hides: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg[0].ctrl[CTL_BLINK] && !r.blink_on |=> !fetch_req[0])
        else $error("blinked-off cursor requested a fetch");

    a_left_of_box: assert property (@(posedge clk) disable iff (!nrst)
        ce && cfg[0].ctrl[CTL_ORG] && h_pos < cfg[0].x |=> !fetch_req[0])
        else $error("fetch left of cursor rectangle");

    a_region_base: assert property (@(posedge clk) disable iff (!nrst)
        $past(ce) && fetch_req[0] && $past(!cfg[0].ctrl[CTL_VEXT])
        |-> ((fetch_addr[0] - $past(fb_start)) >> 12)
            == 24'($past({cfg[0].base_high, cfg[0].base_low[3:0]})))
        else $error("cursor region not offset from frame buffer start");

    a_sel_narrow: assert property (@(posedge clk) disable iff (!nrst)
        $past(ce) && fetch_req[0] && r.f[0].mode == DHC_M32_AX
        && $past(!cfg[0].ctrl[CTL_VEXT])
        |-> (((fetch_addr[0] - $past(fb_start)) >> 8) & 24'h00_000F)
            == 24'($past(cfg[0].base_low[7:4])))
        else $error("pattern select wrong in narrow mode");

    a_c1_palette: assert property (@(posedge clk) disable iff (!nrst)
        ce && r.f[0].hit && r.f[0].mode == DHC_M64_4C |=> ovl_valid && ovl_index[2])
        else $error("first cursor not using upper alternate entries");

    a_border_lim: assert property (@(posedge clk) disable iff (!nrst)
        ce && r.f[0].hit && border_en |=> !ovl_index[1])
        else $error("first cursor used border entries");

    a_xor_invert: assert property (@(posedge clk) disable iff (!nrst)
        ce && r.f[0].hit && r.f[0].mode == DHC_M64_AX && pat_bits[0] == 2'h3
        |=> ovl_valid && ovl_invert)
        else $error("mask and xor set did not invert");

    a_alt_follow: assert property (@(posedge clk) disable iff (!nrst)
        ce |=> pal_alt_access == $past(pixel_pipeline_config_zero[ALT_SEL_BIT]))
        else $error("alternate palette select not followed");

    c_first_hit: cover property (@(posedge clk) disable iff (!nrst) fetch_req[0]);
    c_both_hit: cover property (@(posedge clk) disable iff (!nrst) &fetch_req);
    c_inverted: cover property (@(posedge clk) disable iff (!nrst) ovl_invert);

endmodule : dhc_cursor

// >>> hw/dhc_pkg.sv
// Purpose: Shared constants and types for the dual hardware cursor block
// Assumes: One pixel clock, inputs synchronous to it
// Notes:   Control byte layout and mode codes are fixed here for all users
package dhc_pkg;

    // ==========================================================
    // Control byte fields and the alternate palette select bit
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_MODE_W   = 3;
    localparam int CTL_VEXT     = 3;
    localparam int CTL_HSTR     = 4;
    localparam int CTL_VSTR     = 5;
    localparam int CTL_BLINK    = 6;
    localparam int CTL_ORG      = 7;
    localparam int ALT_SEL_BIT  = 0;

    typedef enum logic [2:0] {
        DHC_OFF     = 3'h0,
        DHC_M32_AX  = 3'h1,
        DHC_M64_AX  = 3'h2,
        DHC_M64_4C  = 3'h3,
        DHC_M64_3T  = 3'h4,
        DHC_M128_2C = 3'h5,
        DHC_M128_1T = 3'h6,
        DHC_OFF7    = 3'h7
    } dhc_mode_t;

    // ==========================================================
    // Geometry and addressing
    localparam logic [7:0]  W32        = 8'h20;
    localparam logic [7:0]  W64        = 8'h40;
    localparam logic [7:0]  W128       = 8'h80;
    localparam logic [3:0]  LSH_NARROW = 4'h3;
    localparam logic [3:0]  LSH_WIDE   = 4'h4;
    localparam logic [7:0]  PAT_LOW    = 8'h00;
    localparam logic [1:0]  TRANS_3T   = 2'h3;
    localparam logic [2:0]  PAL_C1     = 3'h4;
    localparam logic [2:0]  PAL_C2     = 3'h0;
    localparam logic [3:0]  BLINK_LAST = 4'hF;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  height;
        logic [7:0]  base_low;
        logic [7:0]  base_high;
        logic [11:0] x;
        logic [11:0] y;
    } dhc_cur_cfg_t;

    typedef struct packed {
        logic      hit;
        dhc_mode_t mode;
        logic [6:0]  col;
        logic [23:0] addr;
    } dhc_fetch_t;

    typedef struct packed {
        dhc_fetch_t [1:0] f;
        logic       ovl_valid;
        logic       ovl_invert;
        logic [2:0] ovl_index;
        logic       alt_access;
        logic [2:0] alt_index;
        logic [3:0] blink_cnt;
        logic       blink_on;
    } dhc_state_t;

endpackage : dhc_pkg

// >>> tb/dhc_fb_model.sv
// Purpose: Frame buffer side of the cursor block: answers pattern reads
// Assumes: Answer is combinational on the registered request, as the block expects
// Notes:   Contents are a fixed function of address and column, so the bench predicts them

module dhc_fb_model
    import dhc_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Pattern read request
    input  wire logic [1:0]        fetch_req,
    input  wire logic [1:0][23:0]  fetch_addr,
    input  wire logic [1:0][6:0]   fetch_col,
    // Pattern answer
    output logic [1:0][1:0]        pat_bits
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0][1:0] last;

    // ==========================================================
    // Read-only store; without a request the bus shows the complement of its last value
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (fetch_req[i] === 1'b1) begin
                pat_bits[i] = fetch_addr[i][5:4] ^ fetch_col[i][1:0];
            end else begin
                pat_bits[i] = ~last[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        last <= pat_bits;
    end
endmodule : dhc_fb_model

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the dual hardware cursor block
// Assumes: Both cursors share base and position settings
// Notes:   Every probe drives a position, then samples fetch and overlay stages

module tb_top
    import dhc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, nrst, border_en, panel_active, frame_tick, ovl_valid, ovl_invert;
    logic pal_alt_access;
    dhc_cur_cfg_t [1:0] cfg;
    logic [7:0] pcfg;
    logic [2:0] sub_idx, ovl_index, pal_alt_index;
    logic [11:0] h_pos, v_pos;
    logic [1:0] hsh, vsh, fetch_req, r_req;
    logic [1:0][23:0] fetch_addr, r_addr;
    logic [1:0][6:0] fetch_col, r_col;
    logic [1:0][1:0] pat_bits;
    logic r_val, r_inv;
    logic [2:0] r_idx;
    int n_errors, total_checks;
    localparam logic [11:0] H0 = 12'h050;
    localparam logic [11:0] V0 = 12'h028;
    localparam logic [23:0] FB = 24'h10_0000;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    dhc_cursor u_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .cfg(cfg),
        .pixel_pipeline_config_zero(pcfg), .pal_sub_index(sub_idx), .h_pos(h_pos),
        .v_pos(v_pos), .border_left(12'h010), .border_top(12'h008),
        .border_en(border_en), .panel_active(panel_active), .main_hshift(hsh),
        .main_vshift(vsh), .frame_tick(frame_tick), .fb_start(FB),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_col(fetch_col),
        .pat_bits(pat_bits), .ovl_valid(ovl_valid), .ovl_invert(ovl_invert),
        .ovl_index(ovl_index), .pal_alt_access(pal_alt_access),
        .pal_alt_index(pal_alt_index));

    dhc_fb_model u_fb (.clk(clk), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .fetch_col(fetch_col), .pat_bits(pat_bits));

    // ==========================================================
    // Tasks
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic setc(input int c, input logic [7:0] ctl, input logic [7:0] ht);
        @(posedge clk);
        cfg[c].ctrl   <= ctl;
        cfg[c].height <= ht;
    endtask : setc

    task automatic probe(input logic [11:0] hp, input logic [11:0] vp);
        @(posedge clk);
        h_pos <= hp;
        v_pos <= vp;
        @(posedge clk);
        #1;
        r_req  = fetch_req;
        r_addr = fetch_addr;
        r_col  = fetch_col;
        @(posedge clk);
        #1;
        r_val = ovl_valid;
        r_inv = ovl_invert;
        r_idx = ovl_index;
        // Return on a rising edge so later stimulus lands on the edge
        @(posedge clk);
    endtask : probe

    task automatic finish_test;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #500_000;
        n_errors++;
        finish_test;
    end

    // ==========================================================
    // Tests
    initial begin
        logic [11:0] wd;
        logic [3:0]  sel;
        logic [1:0]  p;
        nrst = 1'b0;
        border_en = 1'b0;
        panel_active = 1'b0;
        frame_tick = 1'b0;
        pcfg = 8'h00;
        sub_idx = 3'h0;
        hsh = 2'h0;
        vsh = 2'h0;
        h_pos = 12'h000;
        v_pos = 12'h000;
        for (int c = 0; c < 2; c++) begin
            cfg[c] = '{8'h00, 8'h00, 8'hF5, 8'h03, 12'h040, 12'h020};
        end
        repeat (12) @(posedge clk);
        chk(24'({fetch_req, ovl_valid, ovl_index, pal_alt_access}), 24'h00_0000);
        nrst <= 1'b1;
        // Address, pattern select and width for every drawing mode
        for (int m = 1; m < 7; m++) begin
            setc(0, 8'(m), 8'h00);
            wd  = (m == 1) ? 12'h020 : ((m < 5) ? 12'h040 : 12'h080);
            sel = (m == 1) ? 4'hF : ((m < 5) ? 4'hC : 4'h8);
            probe(H0 + wd - 12'h001, V0 + 12'h002);
            chk(24'(r_req[0]), 24'h00_0001);
            chk(r_addr[0], FB + {8'h03, 4'h5, sel, 8'h00} + ((m == 1) ? 24'h10 : 24'h20));
            chk(24'(r_col[0]), 24'(wd - 12'h001));
            chk(24'({r_val, r_idx}),
                (m == 2) ? 24'h00_0000 : ((m == 6) ? 24'h00_000C : 24'h00_000D));
            probe(H0 + wd, V0 + 12'h002);
            chk(24'(r_req[0]), 24'h00_0000);
        end
        setc(0, 8'h07, 8'h00);
        probe(H0, V0);
        chk(24'(r_req[0]), 24'h00_0000);
        // Two-plane decode with first cursor colours
        setc(0, 8'h01, 8'h00);
        for (int k = 0; k < 4; k++) begin
            p = 2'(k);
            probe(H0 + 12'(k), V0);
            chk(24'({r_val, r_inv, r_idx}), p[0] ? 24'({p[1], p[1], 3'h0}) :
                24'({2'h2, PAL_C1 | {2'b00, p[1]}}));
        end
        // Four-colour mode, border override, second cursor and priority
        for (int b = 0; b < 2; b++) begin
            border_en <= b[0];
            setc(0, 8'h03, 8'h00);
            for (int k = 0; k < 4; k++) begin
                p = 2'(k);
                probe(H0 + 12'(k), V0);
                chk(24'(r_idx), 24'({1'b1, p[1] & ~b[0], p[0]}));
            end
        end
        border_en <= 1'b0;
        setc(1, 8'h03, 8'h00);
        probe(H0 + 12'h002, V0);
        chk(24'(r_idx), 24'h00_0006);
        setc(0, 8'h00, 8'h00);
        probe(H0 + 12'h002, V0);
        chk(24'({r_req, r_idx}), 24'h00_0012);
        setc(1, 8'h00, 8'h00);
        // Vertical extension keeps the mode width; rows stop at the programmed height
        setc(0, 8'h09, 8'h05);
        probe(H0 + 12'h01F, V0 + 12'h004);
        chk(24'(r_req[0]), 24'h00_0001);
        probe(H0 + 12'h020, V0);
        chk(24'(r_req[0]), 24'h00_0000);
        probe(H0, V0 + 12'h005);
        chk(24'(r_req[0]), 24'h00_0000);
        // Origin at the outer border corner
        setc(0, 8'h81, 8'h00);
        probe(12'h040, 12'h020);
        chk(24'({r_req[0], r_col[0]}), 24'h00_0080);
        // Stretch only on panel and with the cursor's own bits, by the main image's amount
        hsh <= 2'h1;
        vsh <= 2'h1;
        panel_active <= 1'b1;
        setc(0, 8'h31, 8'h00);
        probe(H0 + 12'h030, V0 + 12'h030);
        chk(24'(r_req[0]), 24'h00_0001);
        panel_active <= 1'b0;
        probe(H0 + 12'h030, V0);
        chk(24'(r_req[0]), 24'h00_0000);
        panel_active <= 1'b1;
        setc(0, 8'h01, 8'h00);
        probe(H0 + 12'h030, V0);
        chk(24'(r_req[0]), 24'h00_0000);
        // Blink phase flips after 16 frame ticks
        setc(0, 8'h41, 8'h00);
        for (int t = 0; t < 16; t++) begin
            @(posedge clk);
            frame_tick <= 1'b1;
            @(posedge clk);
            frame_tick <= 1'b0;
            if (t == 14) begin
                probe(H0, V0);
                chk(24'(r_req[0]), 24'h00_0001);
            end
        end
        probe(H0, V0);
        chk(24'(r_req[0]), 24'h00_0000);
        // Alternate palette access follows the select bit
        for (int a = 0; a < 2; a++) begin
            @(posedge clk);
            pcfg    <= 8'(a);
            sub_idx <= 3'h5;
            @(posedge clk);
            #1;
            chk(24'({pal_alt_access, pal_alt_index}), 24'({a[0], 3'h5}));
        end
        finish_test;
    end
endmodule : tb_top
